/* core/peb_irq_bank.sv */
// peripheral interrupt enable bank with the core interrupt control register
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module peb_irq_bank (
  input  wire logic                  clk,            // system clock, 20 MHz
  input  wire logic                  rst,            // async reset, active high
  input  wire logic [peb_pkg::ADDR_W-1:0] addr,      // register address
  input  wire logic [peb_pkg::DATA_W-1:0] wr_data,   // write data
  input  wire logic                  wr_en,          // write strobe
  input  wire logic                  rd_en,          // read strobe
  input  wire peb_pkg::peb_src_s     src_flags,      // peripheral flag levels
  input  wire peb_pkg::peb_core_evt_s core_evt,      // core event pulses
  output logic [peb_pkg::DATA_W-1:0] rd_data,        // read data, cycle after strobe
  output peb_pkg::peb_src_s          src_enables,    // bank enables as held
  output logic                       periph_irq_req, // peripheral request to core
  output logic                       core_irq_req    // combined request to core
);
  import peb_pkg::*;

  logic [DATA_W-1:0] intctl;
  logic [DATA_W-1:0] next_intctl;
  logic [DATA_W-1:0] peb;
  logic [DATA_W-1:0] next_peb;
  logic [DATA_W-1:0] next_rd_data;
  logic              next_periph_irq_req;
  logic              next_core_irq_req;
  peb_src_s          next_src_enables;
  peb_src_s          en_view;
  logic              periph_hit;
  logic              wr_intctl;
  logic              wr_peb;
  logic              glb_en;
  logic              grp_en;
  logic              core_hit;

  assign wr_intctl = wr_en && (addr == INTCTL_ADDR);
  assign wr_peb    = wr_en && (addr == PEB_ADDR);
  assign glb_en    = intctl[GLB_EN_BIT];
  assign grp_en    = intctl[GRP_EN_BIT];

  // live view of the bank, fed to the gate so a new enable acts next edge
  always_comb begin
    en_view.comparator_b    = peb[CMPB_BIT];
    en_view.comparator_a    = peb[CMPA_BIT];
    en_view.waveform_gen    = peb[WAVE_BIT];
    en_view.capture_compare = peb[CCP_BIT];
  end

  peb_gate u_gate (
    .flags   (src_flags),
    .enables (en_view),
    .any_hit (periph_hit)
  );

  // register writes
  always_comb begin
    next_peb    = peb;
    next_intctl = intctl;
    if (wr_peb) begin
      next_peb = wr_data & PEB_MASK;
    end
    if (wr_intctl) begin
      next_intctl = wr_data;
    end
    if (core_evt.timer_overflow) begin
      next_intctl[TMR_FLG_BIT] = 1'b1;
    end
    if (core_evt.ext_pin) begin
      next_intctl[EXT_FLG_BIT] = 1'b1;
    end
    if (core_evt.pin_change) begin
      next_intctl[CHG_FLG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peb    <= PEB_RST;
      intctl <= INTCTL_RST;
    end else begin
      peb    <= next_peb;
      intctl <= next_intctl;
    end
  end

  // read path, answer stands only in the cycle after the strobe
  always_comb begin
    next_rd_data = RD_IDLE;
    if (rd_en) begin
      if (addr == INTCTL_ADDR) begin
        next_rd_data = intctl;
      end else if (addr == PEB_ADDR) begin
        next_rd_data = peb & PEB_MASK;
      end else begin
        next_rd_data = RD_IDLE;
      end
    end
  end

  // request logic
  always_comb begin
    core_hit = (intctl[TMR_EN_BIT] & intctl[TMR_FLG_BIT])
             | (intctl[EXT_EN_BIT] & intctl[EXT_FLG_BIT])
             | (intctl[CHG_EN_BIT] & intctl[CHG_FLG_BIT]);
    next_periph_irq_req = glb_en && grp_en && periph_hit;
    next_core_irq_req   = glb_en && (core_hit || (grp_en && periph_hit));
    next_src_enables    = en_view;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data        <= RD_IDLE;
      periph_irq_req <= 1'b0;
      core_irq_req   <= 1'b0;
      src_enables    <= '0;
    end else begin
      rd_data        <= next_rd_data;
      periph_irq_req <= next_periph_irq_req;
      core_irq_req   <= next_core_irq_req;
      src_enables    <= next_src_enables;
    end
  end

  // helpers: nothing has touched a register since reset
  logic peb_untouched;
  logic next_peb_untouched;
  logic intctl_untouched;
  logic next_intctl_untouched;

  always_comb begin
    next_peb_untouched    = peb_untouched && !wr_peb;
    next_intctl_untouched = intctl_untouched && !wr_intctl && (core_evt == 3'b000);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peb_untouched    <= 1'b1;
      intctl_untouched <= 1'b1;
    end else begin
      peb_untouched    <= next_peb_untouched;
      intctl_untouched <= next_intctl_untouched;
    end
  end

  sequence s_write_peb;
    wr_en && addr == PEB_ADDR;
  endsequence

  sequence s_read_peb;
    rd_en && !wr_en && addr == PEB_ADDR;
  endsequence

  sequence s_read_intctl;
    rd_en && !wr_en && addr == INTCTL_ADDR;
  endsequence

  sequence s_write_intctl;
    wr_en && addr == INTCTL_ADDR && core_evt == 3'b000;
  endsequence

  property p_group_gate;
    @(posedge clk) disable iff (rst)
      periph_irq_req |-> $past(glb_en) && $past(grp_en);
  endproperty
  a_group_gate: assert property (p_group_gate)
    else $error("peripheral request without group and global enable");

  property p_cmpb_block;
    @(posedge clk) disable iff (rst)
      (src_flags == 4'b1000 && !peb[CMPB_BIT]) |=> !periph_irq_req;
  endproperty
  a_cmpb_block: assert property (p_cmpb_block)
    else $error("comparator b request passed while disabled");

  property p_wave_block;
    @(posedge clk) disable iff (rst)
      (src_flags == 4'b0010 && !peb[WAVE_BIT]) |=> !periph_irq_req;
  endproperty
  a_wave_block: assert property (p_wave_block)
    else $error("waveform generator request passed while disabled");

  property p_ccp_pass;
    @(posedge clk) disable iff (rst)
      (src_flags == 4'b0001 && peb[CCP_BIT] && glb_en && grp_en) |=> periph_irq_req;
  endproperty
  a_ccp_pass: assert property (p_ccp_pass)
    else $error("capture compare request blocked while enabled");

  property p_bank_readback;
    @(posedge clk) disable iff (rst)
      s_write_peb ##1 s_read_peb |=> rd_data == ($past(wr_data, 2) & PEB_MASK);
  endproperty
  a_bank_readback: assert property (p_bank_readback)
    else $error("bank readback does not match masked write");

  property p_reset_clear;
    @(posedge clk) disable iff (rst)
      peb_untouched |-> src_enables == '0 && peb == PEB_RST;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("bank enable set without any write since reset");

  property p_intctl_readback;
    @(posedge clk) disable iff (rst)
      s_read_intctl |=> rd_data == $past(intctl);
  endproperty
  a_intctl_readback: assert property (p_intctl_readback)
    else $error("control register read wrong");

  property p_flag_set_wins;
    @(posedge clk) disable iff (rst)
      core_evt.timer_overflow |=> intctl[TMR_FLG_BIT];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("timer flag lost");

  property p_unmapped_zero;
    @(posedge clk) disable iff (rst)
      (rd_en && addr != PEB_ADDR && addr != INTCTL_ADDR) |=> rd_data == RD_IDLE;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_req_follows;
    @(posedge clk) disable iff (rst)
      (glb_en && grp_en && periph_hit) |=> periph_irq_req ##0 core_irq_req;
  endproperty
  a_req_follows: assert property (p_req_follows)
    else $error("enabled pending flag raised no request");

  property p_cmpa_pass;
    @(posedge clk) disable iff (rst)
      (src_flags == 4'b0100 && peb[CMPA_BIT] && glb_en && grp_en) |=> periph_irq_req;
  endproperty
  a_cmpa_pass: assert property (p_cmpa_pass)
    else $error("comparator a request blocked while enabled");

  property p_wave_pass;
    @(posedge clk) disable iff (rst)
      (src_flags == 4'b0010 && peb[WAVE_BIT] && glb_en && grp_en) |=> periph_irq_req;
  endproperty
  a_wave_pass: assert property (p_wave_pass)
    else $error("waveform generator request blocked while enabled");

  property p_ccp_block;
    @(posedge clk) disable iff (rst)
      (src_flags == 4'b0001 && !peb[CCP_BIT]) |=> !periph_irq_req;
  endproperty
  a_ccp_block: assert property (p_ccp_block)
    else $error("capture compare request passed while disabled");

  property p_bank_to_enables;
    @(posedge clk) disable iff (rst)
      s_write_peb |-> ##2 (src_enables.comparator_b == $past(wr_data[CMPB_BIT], 2)
        && src_enables.comparator_a == $past(wr_data[CMPA_BIT], 2)
        && src_enables.waveform_gen == $past(wr_data[WAVE_BIT], 2)
        && src_enables.capture_compare == $past(wr_data[CCP_BIT], 2));
  endproperty
  a_bank_to_enables: assert property (p_bank_to_enables)
    else $error("held enables do not follow the bank write");

  property p_bank_reserved;
    @(posedge clk) disable iff (rst)
      (peb & ~PEB_MASK) == 8'h00;
  endproperty
  a_bank_reserved: assert property (p_bank_reserved)
    else $error("unimplemented bank bit holds a one");

  property p_ctl_reset_clear;
    @(posedge clk) disable iff (rst)
      intctl_untouched |-> intctl == INTCTL_RST;
  endproperty
  a_ctl_reset_clear: assert property (p_ctl_reset_clear)
    else $error("control register not clear after reset");

  property p_intctl_write;
    @(posedge clk) disable iff (rst)
      s_write_intctl |=> intctl == $past(wr_data);
  endproperty
  a_intctl_write: assert property (p_intctl_write)
    else $error("control register write not stored");

  property p_ext_set_wins;
    @(posedge clk) disable iff (rst)
      core_evt.ext_pin |=> intctl[EXT_FLG_BIT];
  endproperty
  a_ext_set_wins: assert property (p_ext_set_wins)
    else $error("external pin flag lost");

  property p_read_idle;
    @(posedge clk) disable iff (rst)
      !rd_en |=> rd_data == RD_IDLE;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data present without a read");

  property p_core_gate;
    @(posedge clk) disable iff (rst)
      core_irq_req |-> $past(glb_en);
  endproperty
  a_core_gate: assert property (p_core_gate)
    else $error("core request without global enable");

endmodule

/* core/peb_pkg.sv */
// shared constants and types for the peripheral interrupt enable bank
package peb_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SRC_N  = 4;

  // register addresses
  localparam logic [ADDR_W-1:0] INTCTL_ADDR = 9'h10B;
  localparam logic [ADDR_W-1:0] PEB_ADDR    = 9'h092;

  // core interrupt control field positions
  localparam int unsigned GLB_EN_BIT  = 7;
  localparam int unsigned GRP_EN_BIT  = 6;
  localparam int unsigned TMR_EN_BIT  = 5;
  localparam int unsigned EXT_EN_BIT  = 4;
  localparam int unsigned CHG_EN_BIT  = 3;
  localparam int unsigned TMR_FLG_BIT = 2;
  localparam int unsigned EXT_FLG_BIT = 1;
  localparam int unsigned CHG_FLG_BIT = 0;

  // enable bank field positions
  localparam int unsigned CMPB_BIT = 5;
  localparam int unsigned CMPA_BIT = 4;
  localparam int unsigned WAVE_BIT = 2;
  localparam int unsigned CCP_BIT  = 0;
  localparam logic [DATA_W-1:0] PEB_MASK = 8'h35;

  // values after reset
  localparam logic [DATA_W-1:0] INTCTL_RST = 8'h00;
  localparam logic [DATA_W-1:0] PEB_RST    = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE    = 8'h00;

  // one bit per peripheral source, same order for flags and enables
  typedef struct packed {
    logic comparator_b;
    logic comparator_a;
    logic waveform_gen;
    logic capture_compare;
  } peb_src_s;

  // core interrupt events, one-cycle pulses
  typedef struct packed {
    logic timer_overflow;
    logic ext_pin;
    logic pin_change;
  } peb_core_evt_s;

endpackage

/* core/peb_gate.sv */
// per-source and gating of flags with their enables
`timescale 1ns/1ps
module peb_gate (
  input  wire peb_pkg::peb_src_s flags,   // source flag levels
  input  wire peb_pkg::peb_src_s enables, // matching enable bits
  output logic                   any_hit  // some flag meets its enable
);
  import peb_pkg::*;

  logic [SRC_N-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < SRC_N; i++) begin : g_src
      assign hit[i] = flags[i] & enables[i];
    end
  endgenerate

  assign any_hit = |hit;

endmodule

/* tb/tb_peripheral_irq_enable_bank.sv */
// self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
      error_cnt++; \
    end \
  end
module tb_peripheral_irq_enable_bank;
  import peb_pkg::*;
  logic                clk;
  logic                rst;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wr_data;
  logic                wr_en;
  logic                rd_en;
  peb_src_s            src_flags;
  peb_core_evt_s       core_evt;
  logic [DATA_W-1:0]   rd_data;
  peb_src_s            src_enables;
  logic                periph_irq_req;
  logic                core_irq_req;
  int                  error_cnt;
  int                  tests_run;
  // bank bit of each source, indexed like the flag struct bits
  localparam logic [7:0] BANK_BIT [4] = '{8'h01, 8'h04, 8'h10, 8'h20};

  peb_irq_bank dut (
    .clk            (clk),
    .rst            (rst),
    .addr           (addr),
    .wr_data        (wr_data),
    .wr_en          (wr_en),
    .rd_en          (rd_en),
    .src_flags      (src_flags),
    .core_evt       (core_evt),
    .rd_data        (rd_data),
    .src_enables    (src_enables),
    .periph_irq_req (periph_irq_req),
    .core_irq_req   (core_irq_req)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                        input string nm);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(nm, exp, rd_data)
  endtask

  // enable lag plus output flop, with margin
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // write then read back with no idle cycle between the two strobes
  task automatic wr_rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                           input logic [DATA_W-1:0] exp, input string nm);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    rd_en   <= 1'b1;
    @(posedge clk);
    rd_en   <= 1'b0;
    #1;
    `CHK(nm, exp, rd_data)
  endtask

  task automatic t_reset_values();
    rd_chk(PEB_ADDR, 8'h00, "bank after reset");
    rd_chk(INTCTL_ADDR, 8'h00, "control after reset");
    `CHK("enables after reset", 4'h0, src_enables)
  endtask

  task automatic t_bank_bits();
    wr(PEB_ADDR, 8'hFF);
    rd_chk(PEB_ADDR, 8'h35, "bank all ones");
    settle();
    `CHK("enables all ones", 4'hF, src_enables)
    wr(PEB_ADDR, 8'hCA);
    rd_chk(PEB_ADDR, 8'h00, "bank unused bits");
    for (int i = 0; i < 4; i++) begin
      wr_rd_chk(PEB_ADDR, BANK_BIT[i], BANK_BIT[i], "bank bit");
      settle();
      `CHK("enable single", 4'(1 << i), src_enables)
    end
  endtask

  task automatic t_unmapped();
    wr(PEB_ADDR, 8'h11);
    wr(9'h093, 8'hFF);
    rd_chk(9'h093, 8'h00, "unmapped read");
    rd_chk(9'h1FF, 8'h00, "top address read");
    rd_chk(PEB_ADDR, 8'h11, "bank after stray write");
  endtask

  task automatic t_gating();
    for (int i = 0; i < 4; i++) begin
      wr(INTCTL_ADDR, 8'hC0);
      // every enable but the source's own: its flag alone must stay blocked
      wr(PEB_ADDR, PEB_MASK & ~BANK_BIT[i]);
      @(posedge clk);
      src_flags <= peb_src_s'(4'(1 << i));
      settle();
      `CHK("own enable off", 1'b0, periph_irq_req)
      wr(PEB_ADDR, BANK_BIT[i]);
      @(posedge clk);
      src_flags <= peb_src_s'(~4'(1 << i));
      settle();
      `CHK("other flags blocked", 1'b0, periph_irq_req)
      @(posedge clk);
      src_flags <= peb_src_s'(4'(1 << i));
      settle();
      `CHK("enabled flag request", 1'b1, periph_irq_req)
      `CHK("core request", 1'b1, core_irq_req)
      wr(INTCTL_ADDR, 8'h80);
      settle();
      `CHK("group enable off", 1'b0, periph_irq_req)
      `CHK("group off core", 1'b0, core_irq_req)
      wr(INTCTL_ADDR, 8'h40);
      settle();
      `CHK("global enable off", 1'b0, periph_irq_req)
      @(posedge clk);
      src_flags <= peb_src_s'(4'h0);
    end
  endtask

  task automatic t_core_evt();
    wr(INTCTL_ADDR, 8'hA0);
    @(posedge clk);
    core_evt <= peb_core_evt_s'(3'b100);
    @(posedge clk);
    core_evt <= peb_core_evt_s'(3'b000);
    settle();
    `CHK("timer core request", 1'b1, core_irq_req)
    `CHK("no peripheral request", 1'b0, periph_irq_req)
    rd_chk(INTCTL_ADDR, 8'hA4, "control with flag");
    wr(INTCTL_ADDR, 8'h00);
    rd_chk(INTCTL_ADDR, 8'h00, "control cleared");
    // pin event and pin change, each under its own enable
    wr(INTCTL_ADDR, 8'h98);
    @(posedge clk);
    core_evt <= peb_core_evt_s'(3'b010);
    @(posedge clk);
    core_evt <= peb_core_evt_s'(3'b001);
    @(posedge clk);
    core_evt <= peb_core_evt_s'(3'b000);
    settle();
    `CHK("pin core request", 1'b1, core_irq_req)
    rd_chk(INTCTL_ADDR, 8'h9B, "control with pin flags");
    // an event in the same cycle as a clearing write keeps its flag
    @(posedge clk);
    addr     <= INTCTL_ADDR;
    wr_data  <= 8'h00;
    wr_en    <= 1'b1;
    core_evt <= peb_core_evt_s'(3'b100);
    @(posedge clk);
    wr_en    <= 1'b0;
    core_evt <= peb_core_evt_s'(3'b000);
    rd_chk(INTCTL_ADDR, 8'h04, "flag set beats clear");
    wr(INTCTL_ADDR, 8'h00);
    settle();
    `CHK("core request cleared", 1'b0, core_irq_req)
  endtask

  // a second reset in mid-run must clear both registers again
  task automatic t_mid_reset();
    wr(PEB_ADDR, 8'h35);
    wr(INTCTL_ADDR, 8'hC8);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(PEB_ADDR, 8'h00, "bank after reset");
    rd_chk(INTCTL_ADDR, 8'h00, "control after reset");
    `CHK("enables after reset", 4'h0, src_enables)
  endtask

  initial begin
    #(50 * 4000);
    error_cnt++;
    give_verdict();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst       = 1'b1;
    addr      = '0;
    wr_data   = '0;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    src_flags = peb_src_s'(4'h0);
    core_evt  = peb_core_evt_s'(3'b000);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_bank_bits();
    t_unmapped();
    t_gating();
    t_core_evt();
    t_mid_reset();
    give_verdict();
  end
endmodule
